// ### hw/lane_mapper_pkg.sv
// Shared constants, types and phase tables of the dual-polarisation DQPSK lane mapper.
//
// How it works
// - A lane bit pair 00, 10, 11, 01 advances the carrier phase by 0, pi/2, pi, 3pi/2.
// - The same table converts bit pairs to phase steps on transmit and back on receive.
// - There are four optical lanes, in-phase and quadrature on each of two polarisations.
// - At link initialisation a client-to-optical lane assignment is chosen, any to any.
// - The chosen assignment stays fixed until the connection ends.
// - Both polarisations use the same table, each driven by its own pair of lanes.
// - Every symbol period carries four bits, two on each polarisation.
// - The receiver decodes the phase step between successive symbols, not absolute phase.
// - Received lanes are put back in client order using the framer's lane identification.
// - Staircase FEC parity is inserted on transmit and stripped on receive.
// - The pre-correction bit error ratio of received data is measured and reported.
// - Every received FEC block is counted and the total is readable.
// - Received FEC blocks that could not be corrected are counted and readable.
// - Symbols leave at 27.95 Gbaud within plus or minus 20 ppm.
// - The nominal line rate equals the OTU4 rate of 111,809,973.568 kbit/s.
package lane_mapper_pkg;

  // ----------------
  // Rates and sizes
  // ----------------
  localparam int  LANES            = 4;
  localparam int  POLS             = 2;
  localparam int  BITS_PER_SYMBOL  = 4;
  localparam int  SYMBOL_RATE_KBD  = 27950000;
  localparam int  SYMBOL_TOL_PPM   = 20;
  localparam real LINE_RATE_KBPS   = 111809973.568;
  localparam int  FEC_BLOCK_SYMS   = 256;
  localparam int  FEC_PARITY_SYMS  = 16;
  localparam int  BER_WINDOW_BLKS  = 1024;
  localparam int  CNT_W            = 32;
  localparam int  ERR_W            = 16;

  // ----------------
  // Reset values
  // ----------------
  localparam logic [7:0] IDENTITY_MAP = 8'he4;
  localparam logic [1:0] PHASE_ZERO   = 2'h0;
  localparam logic [1:0] IQ_AT_ZERO   = 2'h3;

  typedef logic [1:0] quad_t;
  typedef enum logic [1:0] {ST_DOWN, ST_INIT, ST_UP} link_state_t;

  function automatic quad_t pair_to_delta(input logic [1:0] pair);
    case (pair)
      2'h0:    pair_to_delta = 2'h0;
      2'h2:    pair_to_delta = 2'h1;
      2'h3:    pair_to_delta = 2'h2;
      default: pair_to_delta = 2'h3;
    endcase
  endfunction

  function automatic logic [1:0] delta_to_pair(input quad_t delta);
    case (delta)
      2'h0:    delta_to_pair = 2'h0;
      2'h1:    delta_to_pair = 2'h2;
      2'h2:    delta_to_pair = 2'h3;
      default: delta_to_pair = 2'h1;
    endcase
  endfunction

  // Quadrant k sits at 45 + k*90 degrees; {I,Q} is one when the component is positive.
  function automatic logic [1:0] quad_to_iq(input quad_t q);
    quad_to_iq = {~q[1] ^ q[0], ~q[1]};
  endfunction

  function automatic quad_t iq_to_quad(input logic i, input logic q);
    iq_to_quad = {~q, ~i ^ ~q};
  endfunction

  function automatic logic map_is_perm(input logic [7:0] map);
    logic [3:0] seen;
    seen = 4'h0;
    for (int c = 0; c < LANES; c++) begin
      seen[map[2*c +: 2]] = 1'b1;
    end
    map_is_perm = &seen;
  endfunction

endpackage

// ### hw/pol_lane_if.sv
// Per-polarisation carrier between the lane mapper and its phase encoder and decoder.
`timescale 1ns/1ps
interface pol_lane_if;
  logic       en;
  logic       clear;
  logic [1:0] tx_pair;
  logic       tx_i;
  logic       tx_q;
  logic       rx_en;
  logic       rx_i;
  logic       rx_q;
  logic [1:0] rx_pair;

  modport enc  (input en, clear, tx_pair, output tx_i, tx_q);
  modport dec  (input rx_en, clear, rx_i, rx_q, output rx_pair);
  modport ctrl (output en, clear, tx_pair, rx_en, rx_i, rx_q, input tx_i, tx_q, rx_pair);
endinterface

// ### hw/dqpsk_encoder.sv
// Differential phase encoder for one polarisation.
`timescale 1ns/1ps
module dqpsk_encoder (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Lane pair in, constellation signs out
  pol_lane_if.enc  lane
);

  typedef struct packed {
    lane_mapper_pkg::quad_t phase;
    logic [1:0]             iq;
  } enc_state_t;

  localparam enc_state_t ENC_RESET = '{lane_mapper_pkg::PHASE_ZERO,
                                      lane_mapper_pkg::IQ_AT_ZERO};

  enc_state_t st_r;
  enc_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (lane.clear) begin
      st_nxt = ENC_RESET;
    end else if (lane.en) begin
      st_nxt.phase = lane_mapper_pkg::quad_t'(st_r.phase +
                     lane_mapper_pkg::pair_to_delta(lane.tx_pair));
      st_nxt.iq    = lane_mapper_pkg::quad_to_iq(st_nxt.phase);
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_r <= ENC_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lane.tx_i = st_r.iq[1];
  assign lane.tx_q = st_r.iq[0];

endmodule // dqpsk_encoder

// ### hw/dqpsk_decoder.sv
// Differential phase decoder for one polarisation.
`timescale 1ns/1ps
module dqpsk_decoder (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Constellation signs in, lane pair out
  pol_lane_if.dec  lane
);

  typedef struct packed {
    lane_mapper_pkg::quad_t prev;
    logic [1:0]             pair;
  } dec_state_t;

  localparam dec_state_t DEC_RESET = '{lane_mapper_pkg::PHASE_ZERO, 2'h0};

  dec_state_t             st_r;
  dec_state_t             st_nxt;
  lane_mapper_pkg::quad_t cur;

  always_comb begin
    st_nxt = st_r;
    cur    = lane_mapper_pkg::iq_to_quad(lane.rx_i, lane.rx_q);
    if (lane.clear) begin
      st_nxt = DEC_RESET;
    end else if (lane.rx_en) begin
      // Only the step from the last symbol matters, so a fixed carrier rotation cancels.
      st_nxt.pair = lane_mapper_pkg::delta_to_pair(
                      lane_mapper_pkg::quad_t'(cur - st_r.prev));
      st_nxt.prev = cur;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_r <= DEC_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lane.rx_pair = st_r.pair;

endmodule // dqpsk_decoder

// ### hw/dual_pol_dqpsk_lane_mapper.sv
// Top of the dual-polarisation DQPSK lane mapper with FEC slotting and statistics.
`timescale 1ns/1ps
module dual_pol_dqpsk_lane_mapper #(
  parameter int BLOCK_SYMS  = lane_mapper_pkg::FEC_BLOCK_SYMS,
  parameter int PARITY_SYMS = lane_mapper_pkg::FEC_PARITY_SYMS,
  parameter int WINDOW_BLKS = lane_mapper_pkg::BER_WINDOW_BLKS
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // Link control
  input  wire logic        link_init,
  input  wire logic        link_drop,
  input  wire logic [7:0]  tx_map_req,
  output logic             link_up,
  output logic [7:0]       tx_map,
  output logic             tx_map_fallback,
  // Client transmit stream, one bit per client lane
  input  wire logic        tx_valid,
  input  wire logic [3:0]  tx_client_bits,
  output logic             tx_ready,
  // Parity from the external staircase encoder
  output logic             tx_parity_req,
  input  wire logic [3:0]  tx_parity,
  // Optical lanes out
  output logic             tx_sym_valid,
  output logic             first_pol_inphase_lane,
  output logic             first_pol_quadrature_lane,
  output logic             second_pol_inphase_lane,
  output logic             second_pol_quadrature_lane,
  // Optical lanes in, already sampled on this clock
  input  wire logic        rx_sym_valid,
  input  wire logic        rx_first_pol_inphase_lane,
  input  wire logic        rx_first_pol_quadrature_lane,
  input  wire logic        rx_second_pol_inphase_lane,
  input  wire logic        rx_second_pol_quadrature_lane,
  // Lane identification from the framer
  input  wire logic        rx_map_valid,
  input  wire logic [7:0]  rx_map_in,
  output logic             rx_map_locked,
  // Client receive stream
  output logic             rx_valid,
  output logic [3:0]       rx_client_bits,
  output logic             rx_parity_valid,
  output logic [3:0]       rx_parity_bits,
  // Block results from the external staircase decoder
  input  wire logic        fec_blk_done,
  input  wire logic        fec_blk_uncorr,
  input  wire logic [15:0] fec_err_bits,
  // Management statistics
  output logic [31:0]      fec_total_blocks,
  output logic [31:0]      fec_uncorr_blocks,
  output logic [31:0]      ber_err_count,
  output logic [31:0]      ber_window_bits,
  output logic             ber_update
);

  // ----------------
  // Derived sizes
  // ----------------
  localparam int POS_W  = $clog2(BLOCK_SYMS);
  localparam int WIN_W  = $clog2(WINDOW_BLKS + 1);
  localparam int CNT_W  = lane_mapper_pkg::CNT_W;
  localparam logic [POS_W-1:0] DATA_SLOTS = POS_W'(BLOCK_SYMS - PARITY_SYMS);
  localparam logic [POS_W-1:0] LAST_SLOT  = POS_W'(BLOCK_SYMS - 1);
  localparam logic [WIN_W-1:0] LAST_BLK   = WIN_W'(WINDOW_BLKS - 1);
  // Bits that one BER window covers: whole blocks of four-bit symbols.
  localparam logic [CNT_W-1:0] WIN_BITS   =
    CNT_W'(WINDOW_BLKS * BLOCK_SYMS * lane_mapper_pkg::BITS_PER_SYMBOL);

  // ----------------
  // State
  // ----------------
  typedef struct packed {
    lane_mapper_pkg::link_state_t link;
    logic [7:0]                   tx_map;
    logic                         fallback;
    logic [7:0]                   rx_map;
    logic                         rx_lock;
    logic [POS_W-1:0]             tx_pos;
    logic                         tx_sv;
    logic                         rx_dv;
    logic [POS_W-1:0]             rx_pos;
    logic                         rx_valid;
    logic [3:0]                   rx_bits;
    logic                         rx_par_valid;
    logic [CNT_W-1:0]             total_blk;
    logic [CNT_W-1:0]             uncorr_blk;
    logic [WIN_W-1:0]             win_blk;
    logic [CNT_W-1:0]             win_err;
    logic [CNT_W-1:0]             ber_err;
    logic                         ber_upd;
  } top_state_t;

  localparam top_state_t TOP_RESET = '{
    link:         lane_mapper_pkg::ST_DOWN,
    tx_map:       lane_mapper_pkg::IDENTITY_MAP,
    fallback:     1'b0,
    rx_map:       lane_mapper_pkg::IDENTITY_MAP,
    rx_lock:      1'b0,
    tx_pos:       '0,
    tx_sv:        1'b0,
    rx_dv:        1'b0,
    rx_pos:       '0,
    rx_valid:     1'b0,
    rx_bits:      4'h0,
    rx_par_valid: 1'b0,
    total_blk:    '0,
    uncorr_blk:   '0,
    win_blk:      '0,
    win_err:      '0,
    ber_err:      '0,
    ber_upd:      1'b0
  };

  top_state_t st_r;
  top_state_t st_nxt;

  logic       up;
  logic       tx_par_slot;
  logic       tx_take;
  logic [3:0] tx_src;
  logic [3:0] tx_opt;
  logic [3:0] rx_opt;
  logic       rx_par_slot;
  logic [3:0] rx_line;

  // Optical lane order is first in-phase, first quadrature, second in-phase, second quadrature.
  pol_lane_if pol[lane_mapper_pkg::POLS] ();

  // ----------------
  // Per-polarisation phase coding
  // ----------------
  assign rx_line = {rx_second_pol_quadrature_lane, rx_second_pol_inphase_lane,
                    rx_first_pol_quadrature_lane, rx_first_pol_inphase_lane};

  generate
    for (genvar p = 0; p < lane_mapper_pkg::POLS; p++) begin : g_pol
      assign pol[p].en      = tx_take;
      assign pol[p].clear   = !up;
      assign pol[p].tx_pair = {tx_opt[2*p], tx_opt[2*p+1]};
      assign pol[p].rx_en   = up && rx_sym_valid;
      assign pol[p].rx_i    = rx_line[2*p];
      assign pol[p].rx_q    = rx_line[2*p+1];
      assign rx_opt[2*p]    = pol[p].rx_pair[1];
      assign rx_opt[2*p+1]  = pol[p].rx_pair[0];

      dqpsk_encoder u_enc (
        .clock (clock),
        .rstn  (rstn),
        .lane  (pol[p])
      );

      dqpsk_decoder u_dec (
        .clock (clock),
        .rstn  (rstn),
        .lane  (pol[p])
      );
    end
  endgenerate

  // ----------------
  // Transmit slotting and lane assignment
  // ----------------
  assign up          = (st_r.link == lane_mapper_pkg::ST_UP);
  assign tx_par_slot = (st_r.tx_pos >= DATA_SLOTS);
  // Parity slots never wait for the client, so the block cadence cannot slip.
  assign tx_take     = up && (tx_par_slot || tx_valid);
  assign tx_src      = tx_par_slot ? tx_parity : tx_client_bits;

  always_comb begin
    tx_opt = 4'h0;
    for (int o = 0; o < lane_mapper_pkg::LANES; o++) begin
      for (int c = 0; c < lane_mapper_pkg::LANES; c++) begin
        if (st_r.tx_map[2*c +: 2] == o[1:0]) begin
          tx_opt[o] = tx_src[c];
        end
      end
    end
  end

  assign rx_par_slot = (st_r.rx_pos >= DATA_SLOTS);

  // ----------------
  // Next state
  // ----------------
  always_comb begin
    st_nxt         = st_r;
    st_nxt.ber_upd = 1'b0;

    case (st_r.link)
      lane_mapper_pkg::ST_DOWN: begin
        if (link_init) begin
          // A request that is not a permutation would drop a lane, so identity is used.
          if (lane_mapper_pkg::map_is_perm(tx_map_req)) begin
            st_nxt.tx_map   = tx_map_req;
            st_nxt.fallback = 1'b0;
          end else begin
            st_nxt.tx_map   = lane_mapper_pkg::IDENTITY_MAP;
            st_nxt.fallback = 1'b1;
          end
          st_nxt.link = lane_mapper_pkg::ST_INIT;
        end
      end
      lane_mapper_pkg::ST_INIT: begin
        st_nxt.tx_pos = '0;
        st_nxt.rx_pos = '0;
        st_nxt.link   = lane_mapper_pkg::ST_UP;
      end
      lane_mapper_pkg::ST_UP: begin
        // tx_map is left untouched here, whatever link_init does; link_drop resets rx_map to identity unless a framer map is locked in the same cycle.
        if (link_drop) begin
          st_nxt.link    = lane_mapper_pkg::ST_DOWN;
          st_nxt.rx_lock = 1'b0;
          st_nxt.rx_map  = lane_mapper_pkg::IDENTITY_MAP;
        end
      end
      default: begin
        st_nxt.link = lane_mapper_pkg::ST_DOWN;
      end
    endcase

    // Transmit block position.
    st_nxt.tx_sv = tx_take;
    if (tx_take) begin
      st_nxt.tx_pos = (st_r.tx_pos == LAST_SLOT) ? '0 : POS_W'(st_r.tx_pos + 1'b1);
    end

    // Framer lane identification, taken once per connection, but one taken in a link_drop cycle stays locked through the next connection.
    if (up && rx_map_valid && !st_r.rx_lock &&
        lane_mapper_pkg::map_is_perm(rx_map_in)) begin
      st_nxt.rx_map  = rx_map_in;
      st_nxt.rx_lock = 1'b1;
    end

    // Receive: decoder output is one cycle behind the line sample.
    st_nxt.rx_dv        = up && rx_sym_valid;
    st_nxt.rx_valid     = st_r.rx_dv && !rx_par_slot;
    st_nxt.rx_par_valid = st_r.rx_dv && rx_par_slot;
    if (st_r.rx_dv) begin
      for (int c = 0; c < lane_mapper_pkg::LANES; c++) begin
        st_nxt.rx_bits[c] = rx_opt[st_r.rx_map[2*c +: 2]];
      end
      st_nxt.rx_pos = (st_r.rx_pos == LAST_SLOT) ? '0 : POS_W'(st_r.rx_pos + 1'b1);
    end

    // FEC statistics; counters saturate rather than wrap so software never sees a drop.
    if (fec_blk_done) begin
      if (st_r.total_blk != '1) begin
        st_nxt.total_blk = CNT_W'(st_r.total_blk + 1'b1);
      end
      if (fec_blk_uncorr && st_r.uncorr_blk != '1) begin
        st_nxt.uncorr_blk = CNT_W'(st_r.uncorr_blk + 1'b1);
      end
      if (st_r.win_err > ('1 - CNT_W'(fec_err_bits))) begin
        st_nxt.win_err = '1;
      end else begin
        st_nxt.win_err = CNT_W'(st_r.win_err + CNT_W'(fec_err_bits));
      end
      if (st_r.win_blk == LAST_BLK) begin
        st_nxt.ber_err = st_nxt.win_err;
        st_nxt.ber_upd = 1'b1;
        st_nxt.win_err = '0;
        st_nxt.win_blk = '0;
      end else begin
        st_nxt.win_blk = WIN_W'(st_r.win_blk + 1'b1);
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_r <= TOP_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------
  // Outputs
  // ----------------
  assign link_up                    = up;
  assign tx_map                     = st_r.tx_map;
  assign tx_map_fallback            = st_r.fallback;
  assign tx_ready                   = up && !tx_par_slot;
  assign tx_parity_req              = up && tx_par_slot;
  assign tx_sym_valid               = st_r.tx_sv;
  assign first_pol_inphase_lane     = pol[0].tx_i;
  assign first_pol_quadrature_lane  = pol[0].tx_q;
  assign second_pol_inphase_lane    = pol[1].tx_i;
  assign second_pol_quadrature_lane = pol[1].tx_q;
  assign rx_map_locked              = st_r.rx_lock;
  assign rx_valid                   = st_r.rx_valid;
  assign rx_client_bits             = st_r.rx_bits;
  assign rx_parity_valid            = st_r.rx_par_valid;
  assign rx_parity_bits             = st_r.rx_bits;
  assign fec_total_blocks           = st_r.total_blk;
  assign fec_uncorr_blocks          = st_r.uncorr_blk;
  assign ber_err_count              = st_r.ber_err;
  assign ber_window_bits            = WIN_BITS;
  assign ber_update                 = st_r.ber_upd;

endmodule // dual_pol_dqpsk_lane_mapper

// ### verification/dqpsk_ref_pkg.sv
// Bench-side phase-step table and constellation signs.
package dqpsk_ref_pkg;
  function automatic logic [1:0] step(input logic [1:0] pair);
    case (pair)
      2'h2:    step = 2'h1;
      2'h3:    step = 2'h2;
      2'h1:    step = 2'h3;
      default: step = 2'h0;
    endcase
  endfunction
  // Returns {Q, I}; phase zero has both components positive.
  function automatic logic [1:0] qi(input logic [1:0] k);
    qi = {~k[1], ~k[1] ^ k[0]};
  endfunction
endpackage

// ### verification/remote_tx_model.sv
// Remote transmitter model that drives encoded symbols onto the receive lanes.
`timescale 1ns/1ps
module remote_tx_model (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // Optical bits o0..o3 to send
  input  wire logic       send,
  input  wire logic [3:0] bits,
  // Lanes: first I, first Q, second I, second Q
  output logic            sym_valid,
  output logic [3:0]      lanes
);
  logic [3:0] ph_r;
  logic [3:0] ph_nxt;

  always_comb begin
    ph_nxt[1:0] = ph_r[1:0] + dqpsk_ref_pkg::step({bits[0], bits[1]});
    ph_nxt[3:2] = ph_r[3:2] + dqpsk_ref_pkg::step({bits[2], bits[3]});
  end

  // Idle lanes toggle each cycle, so a receiver that ignores valid sees garbage.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ph_r      <= 4'h0;
      sym_valid <= 1'b0;
      lanes     <= 4'hf;
    end else begin
      sym_valid <= send;
      if (send) begin
        ph_r  <= ph_nxt;
        lanes <= {dqpsk_ref_pkg::qi(ph_nxt[3:2]), dqpsk_ref_pkg::qi(ph_nxt[1:0])};
      end else begin
        lanes <= ~lanes;
      end
    end
  end
endmodule // remote_tx_model

// ### verification/lane_mapper_chk.sv
// Port-level assertions for the lane mapper.
`timescale 1ns/1ps
module lane_mapper_chk #(
  parameter int BLOCK_SYMS  = 16,
  parameter int WINDOW_BLKS = 4
) (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rstn,
  // Link control
  input wire logic        link_init,
  input wire logic        link_drop,
  input wire logic        link_up,
  input wire logic [7:0]  tx_map,
  input wire logic        tx_map_fallback,
  // Transmit
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic        tx_parity_req,
  input wire logic        tx_sym_valid,
  input wire logic        first_pol_inphase_lane,
  input wire logic        first_pol_quadrature_lane,
  input wire logic        second_pol_inphase_lane,
  input wire logic        second_pol_quadrature_lane,
  // Receive
  input wire logic        rx_sym_valid,
  input wire logic        rx_valid,
  input wire logic        rx_parity_valid,
  // Statistics
  input wire logic        fec_blk_done,
  input wire logic        fec_blk_uncorr,
  input wire logic [31:0] fec_total_blocks,
  input wire logic [31:0] fec_uncorr_blocks,
  input wire logic [31:0] ber_window_bits,
  input wire logic        ber_update
);
  logic       take;
  logic [3:0] lanes;
  assign take  = (tx_valid & tx_ready) | tx_parity_req;
  assign lanes = {second_pol_quadrature_lane, second_pol_inphase_lane,
                  first_pol_quadrature_lane, first_pol_inphase_lane};

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  AST_READY_SLOT: assert property (tx_ready |-> link_up && !tx_parity_req)
    else $error("tx_ready outside a data slot");
  AST_SYM_TAKE: assert property (1'b1 |=> tx_sym_valid == $past(take))
    else $error("tx_sym_valid without take");
  AST_LANE_HOLD: assert property (link_up && $past(link_up) && !tx_sym_valid |-> $stable(lanes))
    else $error("lanes moved without a symbol");
  AST_MAP_FIXED: assert property (link_up && $past(link_up) |-> $stable(tx_map))
    else $error("map changed while up");
  AST_INIT_LAT: assert property ($rose(link_up) |-> $past(link_init, 2))
    else $error("link_up without init");
  AST_DROP: assert property (link_up && link_drop |=> !link_up)
    else $error("link_drop ignored");
  AST_FALLBACK: assert property (link_up && tx_map_fallback |-> tx_map == 8'he4)
    else $error("fallback map not identity");
  AST_TOTAL: assert property (fec_blk_done && ~&fec_total_blocks
    |=> fec_total_blocks == $past(fec_total_blocks) + 32'h1)
    else $error("block total not incremented");
  AST_UNCORR: assert property (!(fec_blk_done && fec_blk_uncorr) |=> $stable(fec_uncorr_blocks))
    else $error("uncorrectable count moved");
  AST_RX_LAT: assert property (link_up && rx_sym_valid ##1 link_up |=> rx_valid || rx_parity_valid)
    else $error("receive output missing");
  AST_RX_CAUSE: assert property (rx_valid || rx_parity_valid |-> $past(rx_sym_valid, 2))
    else $error("receive output without sample");
  AST_WINDOW: assert property (ber_window_bits == WINDOW_BLKS * BLOCK_SYMS * 4)
    else $error("bit window wrong");

  cover property ($rose(link_up));
  cover property (tx_parity_req && tx_valid);
  cover property (ber_update);
endmodule // lane_mapper_chk

bind dual_pol_dqpsk_lane_mapper lane_mapper_chk #(
  .BLOCK_SYMS(BLOCK_SYMS), .WINDOW_BLKS(WINDOW_BLKS)) chk (.*);

// ### verification/test_dual_pol_dqpsk_lane_mapper.sv
// Self-checking bench for the dual-polarisation DQPSK lane mapper.
`timescale 1ns/1ps
module test_dual_pol_dqpsk_lane_mapper;
  localparam int BS = 16;
  localparam int PS = 2;
  localparam int WB = 4;
  logic        clock, rstn, link_init, link_drop, link_up, tx_map_fallback;
  logic [7:0]  tx_map_req, tx_map, rx_map_in, map, rmap;
  logic        tx_valid, tx_ready, tx_parity_req, tx_sym_valid, have_prev;
  logic [3:0]  tx_client_bits, tx_parity, rx_client_bits, rx_parity_bits;
  logic        first_pol_inphase_lane, first_pol_quadrature_lane;
  logic        second_pol_inphase_lane, second_pol_quadrature_lane;
  logic        rx_sym_valid, rx_first_pol_inphase_lane, rx_first_pol_quadrature_lane;
  logic        rx_second_pol_inphase_lane, rx_second_pol_quadrature_lane;
  logic        rx_map_valid, rx_map_locked, rx_valid, rx_parity_valid;
  logic        fec_blk_done, fec_blk_uncorr, ber_update, rx_send;
  logic [15:0] fec_err_bits;
  logic [31:0] fec_total_blocks, fec_uncorr_blocks, ber_err_count, ber_window_bits;
  logic [3:0]  rx_bits, rx_lanes, tx_lanes, ph, exp_tx;
  int          mismatches, comparisons, pos;

  dual_pol_dqpsk_lane_mapper #(.BLOCK_SYMS(BS), .PARITY_SYMS(PS), .WINDOW_BLKS(WB)) DUT (.*);
  remote_tx_model far (.clock(clock), .rstn(rstn), .send(rx_send), .bits(rx_bits),
                       .sym_valid(rx_sym_valid), .lanes(rx_lanes));
  assign {rx_second_pol_quadrature_lane, rx_second_pol_inphase_lane,
          rx_first_pol_quadrature_lane, rx_first_pol_inphase_lane} = rx_lanes;
  assign tx_lanes = {second_pol_quadrature_lane, second_pol_inphase_lane,
                     first_pol_quadrature_lane, first_pol_inphase_lane};

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // ----------------
  // Compare and close
  // ----------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    if (mismatches == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------
  // Scenarios
  // ----------------
  task automatic link_start(input logic [7:0] m, input logic [7:0] e);
    @(posedge clock);
    link_init  <= 1'b1;
    tx_map_req <= m;
    @(posedge clock);
    link_init <= 1'b0;
    @(negedge clock);
    cmp(link_up, 0);
    cmp(tx_map, e);
    cmp(tx_map_fallback, m != e);
    @(negedge clock);
    cmp(link_up, 1);
    map = e;
    ph = 4'h0;
    pos = 0;
    have_prev = 1'b0;
  endtask

  // Each edge takes one symbol, data or parity, so the stream runs back to back.
  task automatic tx_sym(input logic [3:0] b);
    logic [3:0] o;
    @(posedge clock);
    tx_valid       <= 1'b1;
    tx_client_bits <= b;
    tx_parity      <= ~b;
    @(negedge clock);
    if (have_prev) begin
      cmp(tx_sym_valid, 1);
      cmp(tx_lanes, exp_tx);
    end
    cmp(tx_parity_req, pos >= BS - PS);
    cmp(tx_ready, pos < BS - PS);
    o = 4'h0;
    for (int c = 0; c < 4; c++) o[map[2*c +: 2]] = b[c] ^ (pos >= BS - PS);
    ph = {ph[3:2] + dqpsk_ref_pkg::step({o[2], o[3]}), ph[1:0] + dqpsk_ref_pkg::step({o[0], o[1]})};
    exp_tx = {dqpsk_ref_pkg::qi(ph[3:2]), dqpsk_ref_pkg::qi(ph[1:0])};
    pos = (pos + 1) % BS;
    have_prev = 1'b1;
  endtask

  task automatic tx_end;
    @(posedge clock);
    tx_valid <= 1'b0;
    @(negedge clock);
    cmp(tx_sym_valid, 1);
    cmp(tx_lanes, exp_tx);
    @(negedge clock);
    cmp(tx_sym_valid, 0);
    cmp(tx_lanes, exp_tx);
  endtask

  task automatic rx_sym(input logic [3:0] o, input logic par);
    logic [3:0] e;
    int         n;
    for (int c = 0; c < 4; c++) e[c] = o[rmap[2*c +: 2]];
    @(posedge clock);
    rx_send <= 1'b1;
    rx_bits <= o;
    @(posedge clock);
    rx_send <= 1'b0;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (!(rx_valid | rx_parity_valid) && n < 8);
    if (!(rx_valid | rx_parity_valid)) begin
      cmp(0, 1);
      conclude();
    end
    cmp(rx_valid, !par);
    cmp(rx_parity_valid, par);
    cmp(par ? rx_parity_bits : rx_client_bits, e);
  endtask

  task automatic sc_rx;
    rmap = 8'h1b;
    @(posedge clock);
    rx_map_valid <= 1'b1;
    rx_map_in    <= 8'h00;
    @(posedge clock);
    rx_map_in <= rmap;
    @(negedge clock);
    cmp(rx_map_locked, 0);
    @(posedge clock);
    rx_map_valid <= 1'b0;
    @(negedge clock);
    cmp(rx_map_locked, 1);
    for (int i = 0; i < BS; i++) rx_sym(4'(i * 7), i >= BS - PS);
  endtask

  task automatic sc_stats;
    logic [15:0] errs [4];
    int          n;
    errs = '{16'h3, 16'h5, 16'h0, 16'h7};
    for (int i = 0; i < WB; i++) begin
      @(posedge clock);
      fec_blk_done   <= 1'b1;
      fec_err_bits   <= errs[i];
      fec_blk_uncorr <= (i == 1);
    end
    @(posedge clock);
    fec_blk_done <= 1'b0;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (!ber_update && n < 8);
    cmp(ber_update, 1);
    if (ber_update !== 1'b1) conclude();
    cmp(ber_err_count, 32'hf);
    cmp(ber_window_bits, WB * BS * 4);
    cmp(fec_total_blocks, WB);
    cmp(fec_uncorr_blocks, 1);
  endtask

  task automatic sc_hold;
    @(posedge clock);
    link_init  <= 1'b1;
    tx_map_req <= 8'h1b;
    @(posedge clock);
    link_init <= 1'b0;
    repeat (2) @(negedge clock);
    cmp(tx_map, map);
    @(posedge clock);
    link_drop <= 1'b1;
    @(posedge clock);
    link_drop <= 1'b0;
    @(negedge clock);
    cmp(link_up, 0);
    cmp(rx_map_locked, 0);
  endtask

  initial begin
    mismatches = 0;
    comparisons = 0;
    {rstn, link_init, link_drop, tx_valid, rx_send, rx_map_valid} = '0;
    {fec_blk_done, fec_blk_uncorr, fec_err_bits, rx_map_in, rx_bits} = '0;
    {tx_client_bits, tx_parity} = '0;
    tx_map_req = 8'he4;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    @(negedge clock);
    cmp(link_up, 0);
    cmp(tx_map, 8'he4);
    cmp(tx_ready, 0);
    cmp(tx_lanes, 4'hf);
    sc_stats();
    link_start(8'h39, 8'h39);
    sc_rx();
    for (int i = 0; i < 2 * BS; i++) tx_sym(4'(i));
    tx_end();
    sc_hold();
    link_start(8'h00, 8'he4);
    tx_sym(4'h6);
    tx_sym(4'h9);
    tx_end();
    conclude();
  end
endmodule // test_dual_pol_dqpsk_lane_mapper
